// ===== design/shr_cfg.svh
// constants of the sensor host register port
// assumes a 100 MHz ref_clk_i; serial pins are asynchronous to it
`ifndef SHR_CFG_SVH
`define SHR_CFG_SVH
`define SHR_FIFO_ADDR 15'h0040
`define SHR_FIFO_PRE 15'h003F
`define SHR_LAST_ADDR 15'h0277
`define SHR_SHORT_PAD 8'h00
`define SHR_I2C_DEV 7'h24
`define SHR_SEQ_MAX 4'hF
`define SHR_INT_W 16
`define SHR_NSTAT 6
`define SHR_BIT_LAST 4'h7
`define SHR_BIT_ACK 4'h8
`define SHR_CNT_ONE 4'h1
`endif

// ===== design/shr_pkg.sv
// types of the sensor host register port
// used by shr_port together with shr_cfg.svh
`include "shr_cfg.svh"
package shr_pkg;
  typedef enum logic [2:0] {
    I_IDLE = 3'h0, I_DEV = 3'h1, I_ACK = 3'h3, I_RX = 3'h2,
    I_TX = 3'h6, I_MACK = 3'h7
  } shr_i2c_e;
  typedef enum logic [1:0] {
    PH_A0 = 2'h0, PH_A1 = 2'h1, PH_DATA = 2'h3
  } shr_ph_e;
  typedef struct packed {
    logic [3:0] s1, s2, s3;
    shr_i2c_e ist;
    shr_ph_e ph;
    logic [3:0] cnt;
    logic [7:0] sh, tx, wbuf;
    logic rd, whalf, rhalf, ackon, ld, inc, we, pop, miso, oen;
    logic [14:0] addr;
    logic [15:0] wdata;
    logic [3:0] seq;
    logic [5:0] pend;
    logic [47:0] snap;
    logic prdy, ov, skv, ix, iy;
    logic [7:0] od, skd;
    logic [3:0] gp;
  } shr_st_s;
endpackage

// ===== design/shr_port.sv
// host register port: spi or i2c slave, status bytes, interrupt pins
// assumes register file and fifo on ref_clk_i answer combinationally
//
// Notes on behaviour
// [RULE1] set selection bits append status bytes per packet
// [RULE2] 4-bit sequence counter wraps after 15
// [RULE3] summary byte: any flags, sequence counter
// [RULE4] bytes 1, 2 carry data-update flags
// [RULE5] byte 3 carries level-0 flags A..H
// [RULE6] byte 4 level-1 flags; increasing order
// [RULE7] byte 5 carries upper level flags
// [RULE8] two interrupt outputs, any of four pins
// [RULE9] separate x and y enables per bit
// [RULE10] interrupt is or of enabled status bits
// [RULE11] sequence bits may appear on pins
// [RULE12] serial ports run from host clock only; here the host clock is sampled on ref_clk_i to find its edges
// [RULE13] host waits for power-on reset release
// [RULE14] 16-bit registers, 15-bit address, fifo address
// [RULE15] auto-increment except fifo, below, last address
// [RULE16] fifo address reads return successive bytes
// [RULE17] spi write commits only whole 16 bits
// [RULE18] spi burst write advances address per word
// [RULE19] spi read shifts msb first, continues
// [RULE20] host reads fifo byte by byte
// [RULE21] i2c slave; first address bit picks length
// [RULE22] short address only up to 0x007F
// [RULE23] i2c write acks, commits pairs, increments
// [RULE24] i2c read: ack, then bytes while acked
// [RULE25] host ends read with nack and stop
`timescale 1ns/100ps
module shr_port
  import shr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic mode_i2c_i,
  input wire logic spi_sclk_i,
  input wire logic spi_csn_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  input wire logic i2c_scl_i,
  input wire logic i2c_sda_i,
  output logic i2c_sda_o,
  output logic i2c_sda_oe_n_o,
  output logic [14:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_we_o,
  input wire logic [15:0] reg_rdata_i,
  input wire logic [7:0] fifo_byte_i,
  output logic fifo_pop_o,
  input wire logic seq_step_i,
  input wire logic packet_end_i,
  output logic pkt_ready_o,
  input wire logic [5:0] status_sel_i,
  input wire logic [11:0] data_flag_i,
  input wire logic [11:0] threshold0_flag_i,
  input wire logic [11:0] threshold1_flag_i,
  output logic [7:0] stat_data_o,
  output logic stat_valid_o,
  input wire logic stat_ready_i,
  input wire logic [`SHR_INT_W-1:0] int_status_i,
  input wire logic [`SHR_INT_W-1:0] int_x_en_i,
  input wire logic [`SHR_INT_W-1:0] int_y_en_i,
  input wire logic int_x_route_i,
  input wire logic [1:0] int_x_pin_i,
  input wire logic int_y_route_i,
  input wire logic [1:0] int_y_pin_i,
  input wire logic seq_on_pins_i,
  output logic int_x_o,
  output logic int_y_o,
  output logic [3:0] general_pin_o
);
  shr_st_s s_ff;
  shr_st_s nxt_s;
  logic c, cp, d, dp, csn, i2c, rise, fall;

  // edges found by sampling the host clock on the local ref_clk_i through synchroniser flops
  assign c = s_ff.s2[0]; // [RULE12]
  assign cp = s_ff.s3[0];
  assign d = s_ff.s2[1];
  assign dp = s_ff.s3[1];
  assign csn = s_ff.s2[2];
  assign i2c = s_ff.s2[3];
  assign rise = c & ~cp;
  assign fall = ~c & cp;

  function automatic logic [14:0] adv(input logic [14:0] a);
    if (a == `SHR_FIFO_ADDR || a == `SHR_FIFO_PRE || a == `SHR_LAST_ADDR)
      return a; // [RULE15]
    return a + 15'h1;
  endfunction

  always_comb
  begin
    logic bev;
    logic found;
    logic [7:0] bval;
    logic [7:0] pb;
    nxt_s = s_ff;
    bev = 1'b0;
    found = 1'b0;
    bval = s_ff.sh;
    pb = '0;
    nxt_s.we = 1'b0;
    nxt_s.pop = 1'b0;
    nxt_s.ld = 1'b0;
    nxt_s.inc = 1'b0;
    nxt_s.s1 = {mode_i2c_i, spi_csn_n_i,
      mode_i2c_i ? i2c_sda_i : spi_mosi_i,
      mode_i2c_i ? i2c_scl_i : spi_sclk_i};
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    // increment one cycle late so a write strobe shows its own address
    if (s_ff.inc)
      nxt_s.addr = adv(s_ff.addr); // [RULE15]
    if (s_ff.ld)
    begin
      if (s_ff.addr == `SHR_FIFO_ADDR)
      begin
        pb = fifo_byte_i; // [RULE16]
        nxt_s.pop = 1'b1;
      end
      else
      begin
        pb = s_ff.rhalf ? reg_rdata_i[7:0] : reg_rdata_i[15:8]; // [RULE14]
        nxt_s.inc = s_ff.rhalf;
        nxt_s.rhalf = ~s_ff.rhalf;
      end
      nxt_s.tx = pb;
      if (i2c)
      begin
        nxt_s.oen = pb[7]; // [RULE24]
        nxt_s.cnt = `SHR_CNT_ONE;
      end
    end
    if (!i2c)
    begin
      nxt_s.oen = 1'b1;
      nxt_s.ist = I_IDLE;
      if (csn)
      begin
        nxt_s.ph = PH_A0;
        nxt_s.cnt = '0;
        nxt_s.whalf = 1'b0; // [RULE17]
        nxt_s.rhalf = 1'b0;
      end
      else
      begin
        if (rise)
        begin
          nxt_s.sh = {s_ff.sh[6:0], d};
          nxt_s.cnt = s_ff.cnt + `SHR_CNT_ONE;
          if (s_ff.cnt == `SHR_BIT_LAST)
          begin
            bev = 1'b1;
            bval = nxt_s.sh;
            nxt_s.cnt = '0;
          end
        end
        if (fall && s_ff.ph == PH_DATA && s_ff.rd)
          nxt_s.miso = s_ff.tx[3'(`SHR_BIT_LAST - s_ff.cnt)]; // [RULE19]
      end
    end
    else if (c && cp && dp && !d)
    begin
      nxt_s.ist = I_DEV;
      nxt_s.cnt = '0;
      nxt_s.oen = 1'b1;
    end
    else if (c && cp && !dp && d)
    begin
      nxt_s.ist = I_IDLE;
      nxt_s.oen = 1'b1; // [RULE25]
      nxt_s.ph = PH_A0;
      nxt_s.whalf = 1'b0;
      nxt_s.rhalf = 1'b0;
    end
    else
    begin
      case (s_ff.ist)
        I_DEV, I_RX:
          if (rise)
          begin
            nxt_s.sh = {s_ff.sh[6:0], d};
            nxt_s.cnt = s_ff.cnt + `SHR_CNT_ONE;
            if (s_ff.cnt == `SHR_BIT_LAST)
            begin
              nxt_s.ackon = 1'b0;
              nxt_s.ist = I_ACK;
              if (s_ff.ist == I_RX)
              begin
                bev = 1'b1;
                bval = nxt_s.sh;
              end
              else if (nxt_s.sh[7:1] == `SHR_I2C_DEV)
              begin
                nxt_s.rd = nxt_s.sh[0]; // [RULE24]
                if (!nxt_s.sh[0])
                  nxt_s.ph = PH_A0;
              end
              else
                nxt_s.ist = I_IDLE;
            end
          end
        I_ACK:
          if (fall)
          begin
            if (!s_ff.ackon)
            begin
              nxt_s.oen = 1'b0; // [RULE23]
              nxt_s.ackon = 1'b1;
            end
            else
            begin
              nxt_s.oen = 1'b1;
              nxt_s.ackon = 1'b0;
              nxt_s.cnt = '0;
              nxt_s.ist = s_ff.rd ? I_TX : I_RX;
              nxt_s.ld = s_ff.rd;
            end
          end
        I_TX:
          if (fall && s_ff.cnt != '0)
          begin
            if (s_ff.cnt == `SHR_BIT_ACK)
            begin
              nxt_s.oen = 1'b1;
              nxt_s.ist = I_MACK;
            end
            else
            begin
              nxt_s.oen = s_ff.tx[3'(`SHR_BIT_LAST - s_ff.cnt)];
              nxt_s.cnt = s_ff.cnt + `SHR_CNT_ONE;
            end
          end
        I_MACK:
          if (rise)
          begin
            if (d)
              nxt_s.ist = I_IDLE; // [RULE25]
            else
              nxt_s.ackon = 1'b1;
          end
          else if (fall && s_ff.ackon)
          begin
            nxt_s.ackon = 1'b0;
            nxt_s.ist = I_TX; // [RULE24]
            nxt_s.cnt = '0;
            nxt_s.ld = 1'b1;
          end
        default:
          nxt_s.ist = I_IDLE;
      endcase
    end
    if (bev)
    begin
      case (s_ff.ph)
        PH_A0:
        begin
          nxt_s.rhalf = 1'b0;
          nxt_s.whalf = 1'b0;
          if (i2c && !bval[7])
          begin
            nxt_s.addr = {`SHR_SHORT_PAD, bval[6:0]}; // [RULE21]
            nxt_s.ph = PH_DATA;
          end
          else
          begin
            if (i2c)
              nxt_s.addr[14:8] = bval[6:0]; // [RULE21]
            else
              nxt_s.addr[14:7] = bval;
            nxt_s.ph = PH_A1;
          end
        end
        PH_A1:
        begin
          nxt_s.ph = PH_DATA;
          if (i2c)
            nxt_s.addr[7:0] = bval;
          else
          begin
            nxt_s.addr[6:0] = bval[7:1]; // [RULE17]
            nxt_s.rd = ~bval[0];
            nxt_s.ld = ~bval[0]; // [RULE19]
          end
        end
        default:
          if (s_ff.rd)
            nxt_s.ld = 1'b1; // [RULE19]
          else if (!s_ff.whalf)
          begin
            nxt_s.wbuf = bval;
            nxt_s.whalf = 1'b1;
          end
          else
          begin
            nxt_s.wdata = {s_ff.wbuf, bval}; // [RULE23]
            nxt_s.we = 1'b1; // [RULE17]
            nxt_s.whalf = 1'b0;
            nxt_s.inc = 1'b1; // [RULE18]
          end
      endcase
    end
    if (seq_step_i)
      nxt_s.seq = s_ff.seq + `SHR_CNT_ONE; // [RULE2]
    if (s_ff.ov && stat_ready_i)
    begin
      nxt_s.ov = s_ff.skv;
      nxt_s.od = s_ff.skd;
      nxt_s.skv = 1'b0;
    end
    // a packet end while bytes are pending is dropped; see pkt_ready_o
    if (packet_end_i && s_ff.pend == '0)
    begin
      nxt_s.snap = {threshold1_flag_i[11:8], threshold0_flag_i[11:8], // [RULE7]
        threshold1_flag_i[7:0], // [RULE6]
        threshold0_flag_i[7:0], // [RULE5]
        4'h0, data_flag_i[11:8], data_flag_i[7:0], // [RULE4]
        2'b00, |threshold1_flag_i, |threshold0_flag_i, s_ff.seq}; // [RULE3]
      nxt_s.pend = status_sel_i; // [RULE1]
    end
    else if (s_ff.pend != '0 && !s_ff.skv)
    begin
      // lowest pending byte first keeps increasing byte order
      for (int i = 0; i < `SHR_NSTAT; i++)
      begin
        if (s_ff.pend[i] && !found)
        begin
          found = 1'b1;
          pb = s_ff.snap[8*i +: 8]; // [RULE6]
          nxt_s.pend[i] = 1'b0;
        end
      end
      if (!nxt_s.ov)
      begin
        nxt_s.ov = 1'b1;
        nxt_s.od = pb;
      end
      else
      begin
        nxt_s.skv = 1'b1;
        nxt_s.skd = pb;
      end
    end
    nxt_s.prdy = (nxt_s.pend == '0);
    nxt_s.ix = |(int_status_i & int_x_en_i); // [RULE9] [RULE10]
    nxt_s.iy = |(int_status_i & int_y_en_i); // [RULE10]
    for (int p = 0; p < 4; p++)
    begin
      if (int_x_route_i && int_x_pin_i == 2'(p))
        nxt_s.gp[p] = s_ff.ix; // [RULE8]
      else if (int_y_route_i && int_y_pin_i == 2'(p))
        nxt_s.gp[p] = s_ff.iy; // [RULE8]
      else
        nxt_s.gp[p] = seq_on_pins_i & s_ff.seq[p]; // [RULE11]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_ff <= '0;
      s_ff.oen <= 1'b1;
      s_ff.prdy <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  assign spi_miso_o = s_ff.miso;
  assign i2c_sda_o = 1'b0;
  assign i2c_sda_oe_n_o = s_ff.oen;
  assign reg_addr_o = s_ff.addr;
  assign reg_wdata_o = s_ff.wdata;
  assign reg_we_o = s_ff.we;
  assign fifo_pop_o = s_ff.pop;
  assign pkt_ready_o = s_ff.prdy;
  assign stat_data_o = s_ff.od;
  assign stat_valid_o = s_ff.ov;
  assign int_x_o = s_ff.ix;
  assign int_y_o = s_ff.iy;
  assign general_pin_o = s_ff.gp;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_stall;
    stat_valid_o && !stat_ready_i;
  endsequence
  sequence s_rx_done;
    s_ff.ist == I_RX ##1 s_ff.ist == I_ACK;
  endsequence
  sequence s_pkt;
    packet_end_i && pkt_ready_o;
  endsequence

  property p_int_x;
    int_status_i[0] && int_x_en_i[0] |=> int_x_o;
  endproperty
  a_int_x: assert property (p_int_x) else $error("int x missed"); // [RULE10]
  property p_seq_wrap;
    seq_step_i && s_ff.seq == `SHR_SEQ_MAX |=> s_ff.seq == '0;
  endproperty
  a_seq_wrap: assert property (p_seq_wrap) else $error("seq wrap"); // [RULE2]
  property p_pend;
    s_pkt |=> s_ff.pend == $past(status_sel_i);
  endproperty
  a_pend: assert property (p_pend) else $error("selection lost"); // [RULE1]
  property p_sum;
    s_pkt |=> s_ff.snap[7:0] == {2'b00, $past(|threshold1_flag_i),
      $past(|threshold0_flag_i), $past(s_ff.seq)};
  endproperty
  a_sum: assert property (p_sum) else $error("summary byte"); // [RULE3]
  property p_stall;
    s_stall |=> stat_valid_o && $stable(stat_data_o);
  endproperty
  a_stall: assert property (p_stall) else $error("word lost"); // [RULE6]
  property p_gpio;
    int_x_route_i |=> general_pin_o[$past(int_x_pin_i)] == $past(int_x_o);
  endproperty
  a_gpio: assert property (p_gpio) else $error("pin route"); // [RULE8]
  property p_fifo;
    fifo_pop_o |-> reg_addr_o == `SHR_FIFO_ADDR;
  endproperty
  a_fifo: assert property (p_fifo) else $error("pop off fifo"); // [RULE16]
  property p_hold;
    s_ff.inc && (s_ff.addr == `SHR_FIFO_ADDR ||
      s_ff.addr == `SHR_FIFO_PRE || s_ff.addr == `SHR_LAST_ADDR)
      |=> $stable(reg_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved"); // [RULE15]
  property p_burst;
    reg_we_o && reg_addr_o < `SHR_FIFO_PRE
      |=> ##1 reg_addr_o == $past(reg_addr_o, 2) + 15'h1;
  endproperty
  a_burst: assert property (p_burst) else $error("no advance"); // [RULE18]
  property p_ack;
    s_rx_done |-> ##[1:12] !i2c_sda_oe_n_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack"); // [RULE23]
endmodule

// ===== test/sensor_host_register_port_bench.sv
// bench of shr_port: spi access, status bytes, interrupt pins
// assumes shr_spi_host as host of both serial modes; sda pulled up
`timescale 1ns/100ps
`include "shr_cfg.svh"
module sensor_host_register_port_bench;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sclk, csn_n, mosi, miso, we, fpop, prdy, sval, ix, iy;
  logic [14:0] addr;
  logic [15:0] wdata;
  logic [7:0] sdat;
  logic [3:0] gpin;
  logic mi2c = 1'b0;
  logic scl, sda_h, sdaoe, sda;
  assign sda = sdaoe ? sda_h : 1'b0;
  logic [7:0] fptr = 8'h00;
  logic [7:0] fexp = 8'h11;
  logic [3:0] seq = 4'h0;
  logic step = 1'b0, pend = 1'b0, srdy = 1'b0, stall = 1'b0;
  logic xr = 1'b0, yr = 1'b0, sqp = 1'b0;
  logic [1:0] xp = 2'h0, yp = 2'h0;
  logic [5:0] sel = 6'h00;
  logic [11:0] dfl = 12'h000, l0 = 12'h000, l1 = 12'h000;
  logic [15:0] ist = 16'h0000, xen = 16'h0000, yen = 16'h0000;
  logic [31:0] wq[$], sq[$];
  int fails = 0;
  int cmp_count = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  function automatic logic [15:0] rmod(input logic [14:0] a);
    return {1'b1, a} ^ 16'h3C5A;
  endfunction
  function automatic logic [31:0] take(ref logic [31:0] q[$]);
    return (q.size() != 0) ? q.pop_front() : 'x;
  endfunction
  shr_spi_host host (
    .ref_clk_i(ref_clk_i), .spi_miso_i(miso), .spi_sclk_o(sclk),
    .spi_csn_n_o(csn_n), .spi_mosi_o(mosi), .i2c_sda_i(sda),
    .i2c_scl_o(scl), .i2c_sda_o(sda_h)
  );
  shr_port dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .mode_i2c_i(mi2c),
    .spi_sclk_i(sclk), .spi_csn_n_i(csn_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .i2c_scl_i(scl), .i2c_sda_i(sda),
    .i2c_sda_o(), .i2c_sda_oe_n_o(sdaoe), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_we_o(we), .reg_rdata_i(rmod(addr)),
    .fifo_byte_i(fptr + 8'h11), .fifo_pop_o(fpop), .seq_step_i(step),
    .packet_end_i(pend), .pkt_ready_o(prdy), .status_sel_i(sel),
    .data_flag_i(dfl), .threshold0_flag_i(l0), .threshold1_flag_i(l1),
    .stat_data_o(sdat), .stat_valid_o(sval), .stat_ready_i(srdy),
    .int_status_i(ist), .int_x_en_i(xen), .int_y_en_i(yen),
    .int_x_route_i(xr), .int_x_pin_i(xp), .int_y_route_i(yr),
    .int_y_pin_i(yp), .seq_on_pins_i(sqp), .int_x_o(ix), .int_y_o(iy),
    .general_pin_o(gpin)
  );
  task automatic chk(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic lim(inout int n);
    @(posedge ref_clk_i);
    n++;
    if (n > 3000)
    begin
      fails++;
      $display("[ERR] wait expected done seen timeout");
      end_sim();
    end
  endtask
  // fifo fetch gets a spurious pop after the last byte of a read burst from it
  always @(posedge ref_clk_i)
  begin
    if (fpop === 1'b1)
      fptr <= fptr + 8'h01;
    srdy <= !stall && ($urandom % 4 != 0);
    if (we === 1'b1)
      chk("reg_write", {1'b0, addr, wdata}, take(wq));
    if (sval === 1'b1 && srdy === 1'b1)
      chk("stat_byte", 32'(sdat), take(sq));
  end
  function automatic logic [14:0] nxt(input logic [14:0] a);
    if (a == `SHR_FIFO_ADDR || a == `SHR_FIFO_PRE || a == `SHR_LAST_ADDR)
      return a;
    return a + 15'h0001;
  endfunction
  task automatic spi_hdr(input logic [14:0] a, input logic w);
    logic [7:0] rx;
    host.sel(1'b1);
    host.xfer(a[14:7], rx);
    host.xfer({a[6:0], w}, rx);
  endtask
  task automatic spi_wr(input logic [14:0] a, input int n, input bit cut);
    logic [15:0] d;
    logic [7:0] rx;
    spi_hdr(a, 1'b1);
    repeat (n)
    begin
      d = 16'($urandom);
      wq.push_back({1'b0, a, d});
      host.xfer(d[15:8], rx);
      host.xfer(d[7:0], rx);
      a = nxt(a);
    end
    if (cut)
      host.xfer(8'hC3, rx);
    host.sel(1'b0);
  endtask
  task automatic spi_rd(input logic [14:0] a, input int n);
    logic [7:0] rx;
    logic [15:0] e;
    spi_hdr(a, 1'b0);
    for (int k = 0; k < n; k++)
    begin
      e = rmod(a);
      host.xfer(8'h00, rx);
      if (a == `SHR_FIFO_ADDR)
      begin
        chk("fifo_byte", 32'(rx), 32'(fexp));
        fexp++;
      end
      else
        chk("read_byte", 32'(rx), 32'(k[0] ? e[7:0] : e[15:8]));
      if (k[0])
        a = nxt(a);
    end
    host.sel(1'b0);
  endtask
  task automatic i2c_wr(input logic [14:0] a, input int n);
    logic [15:0] d;
    logic [7:0] rx;
    logic k;
    host.i2c_start();
    host.i2c_byte({`SHR_I2C_DEV, 1'b0}, 1'b1, rx, k);
    chk("i2c_dev_ack", 32'(k), 32'd0);
    if (a <= 15'h007F)
      host.i2c_byte({1'b0, a[6:0]}, 1'b1, rx, k);
    else
    begin
      host.i2c_byte({1'b1, a[14:8]}, 1'b1, rx, k);
      host.i2c_byte(a[7:0], 1'b1, rx, k);
    end
    repeat (n)
    begin
      d = 16'($urandom);
      wq.push_back({1'b0, a, d});
      host.i2c_byte(d[15:8], 1'b1, rx, k);
      host.i2c_byte(d[7:0], 1'b1, rx, k);
      chk("i2c_ack", 32'(k), 32'd0);
      a = nxt(a);
    end
    host.i2c_stop();
  endtask
  task automatic i2c_rd(input logic [14:0] a, input int n);
    logic [15:0] e;
    logic [7:0] rx;
    logic k;
    host.i2c_start();
    host.i2c_byte({`SHR_I2C_DEV, 1'b0}, 1'b1, rx, k);
    host.i2c_byte({1'b0, a[6:0]}, 1'b1, rx, k);
    host.i2c_start();
    host.i2c_byte({`SHR_I2C_DEV, 1'b1}, 1'b1, rx, k);
    chk("i2c_rd_ack", 32'(k), 32'd0);
    for (int j = 0; j < n; j++)
    begin
      e = rmod(a);
      host.i2c_byte(8'hFF, j == n - 1, rx, k);
      chk("i2c_read", 32'(rx), 32'(j[0] ? e[7:0] : e[15:8]));
      if (j[0])
        a = nxt(a);
    end
    host.i2c_stop();
  endtask
  task automatic pkt(input logic [5:0] s, input int steps);
    int n;
    logic [11:0] d, z, o;
    logic [7:0] b[6];
    repeat (steps)
    begin
      step <= 1'b1;
      seq = seq + 4'h1;
      @(posedge ref_clk_i);
      step <= 1'b0;
      @(posedge ref_clk_i);
    end
    n = 0;
    while (prdy !== 1'b1)
      lim(n);
    d = 12'($urandom);
    z = 12'($urandom);
    o = 12'($urandom);
    sel <= s;
    dfl <= d;
    l0 <= z;
    l1 <= o;
    @(posedge ref_clk_i);
    // held for two edges; the second one must be refused
    pend <= 1'b1;
    b[0] = {2'b00, |o, |z, seq};
    b[1] = d[7:0];
    b[2] = {4'h0, d[11:8]};
    b[3] = z[7:0];
    b[4] = o[7:0];
    b[5] = {o[11:8], z[11:8]};
    for (int k = 0; k < 6; k++)
      if (s[k])
        sq.push_back(32'(b[k]));
    repeat (2) @(posedge ref_clk_i);
    pend <= 1'b0;
  endtask
  task automatic irq_once;
    logic [15:0] s, x, y;
    logic [6:0] r;
    logic [3:0] g;
    s = 16'($urandom);
    x = 16'($urandom) & 16'($urandom) & 16'($urandom);
    y = 16'($urandom) & 16'($urandom) & 16'($urandom);
    r = 7'($urandom);
    ist <= s;
    xen <= x;
    yen <= y;
    xr <= r[0];
    yr <= r[1];
    xp <= r[3:2];
    yp <= r[5:4];
    sqp <= r[6];
    repeat (4) @(posedge ref_clk_i);
    chk("int_x", 32'(ix), 32'(|(s & x)));
    chk("int_y", 32'(iy), 32'(|(s & y)));
    for (int p = 0; p < 4; p++)
      g[p] = (r[0] && r[3:2] == p) ? |(s & x) :
        (r[1] && r[5:4] == p) ? |(s & y) : r[6] & seq[p];
    chk("general_pin", 32'(gpin), 32'(g));
  endtask
  initial
  begin
    int n;
    void'($urandom(7));
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    spi_wr(15'h003E, 3, 1'b0);
    spi_wr(15'h0276, 2, 1'b1);
    spi_wr(15'($urandom % 15'h0200), 4, 1'b1);
    n = 0;
    while (wq.size() != 0)
      lim(n);
    $display("test spi_write done");
    spi_rd(15'h003E, 6);
    spi_rd(`SHR_FIFO_ADDR, 5);
    spi_rd(15'h0275, 8);
    $display("test spi_read done");
    mi2c <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    i2c_wr(15'h0012, 2);
    i2c_wr(15'h0150, 1);
    i2c_rd(15'h0012, 4);
    n = 0;
    while (wq.size() != 0)
      lim(n);
    chk("sda_release", 32'(sdaoe), 32'd1);
    mi2c <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    $display("test i2c done");
    stall <= 1'b1;
    pkt(6'h3F, 1);
    repeat (20) @(posedge ref_clk_i);
    chk("stat_hold", 32'(sval), 32'd1);
    chk("stat_head", 32'(sdat), sq[0]);
    stall <= 1'b0;
    for (int i = 0; i < 14; i++)
      pkt(6'($urandom), 2);
    n = 0;
    while (sq.size() != 0)
      lim(n);
    $display("test status_bytes done");
    repeat (12) irq_once();
    $display("test interrupts done");
    end_sim();
  end
endmodule

// ===== test/shr_spi_host.sv
// host side model: spi mode 0 master and i2c master for the register port
// assumes ref_clk_i at 100 MHz; sclk period is 8 clocks (80 ns)
`timescale 1ns/100ps
module shr_spi_host (
  input wire logic ref_clk_i,
  input wire logic spi_miso_i,
  output logic spi_sclk_o,
  output logic spi_csn_n_o,
  output logic spi_mosi_o,
  input wire logic i2c_sda_i,
  output logic i2c_scl_o,
  output logic i2c_sda_o
);
  // i2c: scl stands high and sda released outside frames
  initial
  begin
    spi_sclk_o = 1'b0;
    spi_csn_n_o = 1'b1;
    spi_mosi_o = 1'b0;
    i2c_scl_o = 1'b1;
    i2c_sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // released mosi flips, so a stale bit never looks like data
  task automatic sel(input logic on);
    tick(4);
    spi_csn_n_o <= ~on;
    if (!on)
      spi_mosi_o <= ~spi_mosi_o;
    tick(4);
  endtask
  // msb first; sclk stands low outside frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      spi_mosi_o <= tx[i];
      tick(4);
      @(negedge ref_clk_i);
      rx[i] = spi_miso_i;
      @(posedge ref_clk_i);
      spi_sclk_o <= 1'b1;
      tick(3);
      spi_sclk_o <= 1'b0;
    end
  endtask
  // sda moves only while scl is low, so no false start or stop
  task automatic i2c_bit(input logic b, output logic r);
    i2c_scl_o <= 1'b0;
    tick(1);
    i2c_sda_o <= b;
    tick(4);
    i2c_scl_o <= 1'b1;
    tick(1);
    @(negedge ref_clk_i);
    r = i2c_sda_i;
    tick(2);
  endtask
  // last is the level driven in the ninth clock; 1 releases sda
  task automatic i2c_byte(input logic [7:0] tx, input logic last,
    output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      i2c_bit(tx[i], rx[i]);
    i2c_bit(last, ack);
  endtask
  task automatic i2c_start;
    i2c_scl_o <= 1'b0;
    tick(1);
    i2c_sda_o <= 1'b1;
    tick(4);
    i2c_scl_o <= 1'b1;
    tick(4);
    i2c_sda_o <= 1'b0;
    tick(4);
  endtask
  task automatic i2c_stop;
    i2c_scl_o <= 1'b0;
    tick(1);
    i2c_sda_o <= 1'b0;
    tick(4);
    i2c_scl_o <= 1'b1;
    tick(4);
    i2c_sda_o <= 1'b1;
    tick(4);
  endtask
endmodule
